// ### logic/pip_pkg.sv
// Constants, register map and carrier types of the peripheral interrupt
// enable and priority block. Assumes an APB master with 32-bit data.
// ==========================================================================
// What this block does
// - Enable-two bits seven to four are unimplemented: read zero, writes ignored.
// - Enable-two bit two enables the low-voltage-detect interrupt.
// - Enable-two bit one enables the timer-three overflow interrupt.
// - Enable-two bit zero enables the capture/compare-two interrupt.
// - Every peripheral source has its own priority bit across two priority registers.
// - Priority bits matter only while global priority enable is set.
// - Global priority enable lives in the read/write reset control register.
// - With priority disabled, nothing reaches the CPU unless the peripheral gate is set.
package pip_pkg;

  // ========================================================================
  // Register byte offsets.
  localparam logic [7:0] PIP_OFS_ENABLE_SECOND   = 8'h00;
  localparam logic [7:0] PIP_OFS_PRIORITY_FIRST  = 8'h04;
  localparam logic [7:0] PIP_OFS_PRIORITY_SECOND = 8'h08;
  localparam logic [7:0] PIP_OFS_RESET_CONTROL   = 8'h0c;
  localparam logic [7:0] PIP_OFS_IRQ_GATE        = 8'h10;

  // ========================================================================
  // Field positions.
  localparam int PIP_BIT_CAPCOMP_TWO   = 0;
  localparam int PIP_BIT_TIMER_THREE   = 1;
  localparam int PIP_BIT_LOW_VOLTAGE   = 2;
  localparam int PIP_BIT_BUS_COLLISION = 3;
  localparam int PIP_BIT_GLOBAL_PRIO   = 7;
  localparam int PIP_BIT_IRQ_GATE      = 0;

  // ========================================================================
  // Reset values.
  localparam logic [3:0] PIP_RST_ENABLE_SECOND   = 4'h0;
  localparam logic [7:0] PIP_RST_PRIORITY_FIRST  = 8'hff;
  localparam logic [3:0] PIP_RST_PRIORITY_SECOND = 4'hf;
  localparam logic       PIP_RST_GLOBAL_PRIO    = 1'b0;
  localparam logic       PIP_RST_IRQ_GATE       = 1'b0;

  // ========================================================================
  // Peripheral sources: eight of the first group, four of the second.
  typedef struct packed {
    logic [7:0] first;
    logic [3:0] second;
  } pip_src_t;

  // Requests handed to the CPU vectoring logic.
  typedef struct packed {
    logic high;
    logic low;
  } pip_req_t;

endpackage

// ### logic/pip_src_gate.sv
// Per-source enable and priority gating, reduced to three request lines: high, low and any.
// Assumes flags, enables and priorities are aligned bit for bit.
`timescale 1ns/1ps
module pip_src_gate
#(
  parameter int N = 12
)
(
  input  wire logic [N-1:0] flag_i,     // Source flags.
  input  wire logic [N-1:0] enable_i,   // Source enables.
  input  wire logic [N-1:0] prio_i,     // One is high priority.
  output logic              any_high_o, // An enabled high-priority flag.
  output logic              any_low_o,  // An enabled low-priority flag.
  output logic              any_o       // Any enabled flag at all.
);

  logic [N-1:0] hi_vec;
  logic [N-1:0] lo_vec;

  // ========================================================================
  // Each source is gated by its own enable and steered by its own priority.
  // per-source priority
  for (genvar g = 0; g < N; g++)
  begin : g_src
    assign hi_vec[g] = flag_i[g] & enable_i[g] & prio_i[g];
    assign lo_vec[g] = flag_i[g] & enable_i[g] & ~prio_i[g];
  end

  assign any_high_o = |hi_vec;
  assign any_low_o  = |lo_vec;
  assign any_o      = (|hi_vec) | (|lo_vec);

endmodule

// ### logic/pip_irq_regs.sv
// Peripheral interrupt enable-two, priority-one/two, priority enable and
// peripheral gate registers on APB, with the request steering they drive.
// Assumes flags and the first enable group come from neighbouring logic.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module pip_irq_regs
  import pip_pkg::*;
(
  input  wire logic            MCLK_I,       // Core clock, 250 MHz.
  input  wire logic            ARST_N_I,     // Asynchronous reset, low.
  input  wire logic            PSEL_I,       // APB select.
  input  wire logic            PENABLE_I,    // APB access phase.
  input  wire logic            PWRITE_I,     // APB write when high.
  input  wire logic [7:0]      PADDR_I,      // APB byte address.
  input  wire logic [31:0]     PWDATA_I,     // APB write data.
  output logic      [31:0]     PRDATA_O,     // APB read data.
  output logic                 PREADY_O,     // APB ready.
  output logic                 PSLVERR_O,    // APB error, unmapped address.
  input  wire pip_pkg::pip_src_t FLAG_I,     // Peripheral interrupt flags.
  input  wire logic [7:0]      EN_FIRST_I,   // First enable group.
  output pip_pkg::pip_req_t    REQ_O,        // Requests to the CPU.
  output logic                 PRIO_MODE_O   // Priority scheme armed.
);

  import pip_pkg::*;

  logic [3:0]  enable_second;
  logic [7:0]  priority_first;
  logic [3:0]  priority_second;
  logic        global_priority_enable;
  logic        peripheral_irq_gate;
  logic        wr_fire;
  logic        addr_ok;
  logic [31:0] next_rdata;
  logic        any_high;
  logic        any_low;
  logic        any_req;
  pip_req_t    next_req;

  // ========================================================================
  // Bus decode. The answer is prepared in the setup cycle so the access
  // phase always lasts exactly one cycle.
  assign wr_fire = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;

  always_comb
  begin
    addr_ok    = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (PADDR_I)
      PIP_OFS_ENABLE_SECOND:   next_rdata[3:0] = enable_second;
      PIP_OFS_PRIORITY_FIRST:  next_rdata[7:0] = priority_first;
      PIP_OFS_PRIORITY_SECOND: next_rdata[3:0] = priority_second;
      PIP_OFS_RESET_CONTROL:   next_rdata[PIP_BIT_GLOBAL_PRIO] = global_priority_enable;
      PIP_OFS_IRQ_GATE:        next_rdata[PIP_BIT_IRQ_GATE] = peripheral_irq_gate;
      default:                 addr_ok = 1'b0;
    endcase
  end

  // Ready and error rise in the access phase only, for one cycle.
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & ~addr_ok;
    end
  end

  // Read data is held until the next read setup cycle.
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      PRDATA_O <= 32'h0000_0000;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I)
      PRDATA_O <= next_rdata;
  end

  // ========================================================================
  // Enable-two register; only the low nibble exists.
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      enable_second <= PIP_RST_ENABLE_SECOND;
    else if (wr_fire && PADDR_I == PIP_OFS_ENABLE_SECOND)
      enable_second <= PWDATA_I[3:0];
  end

  // Priority registers reset to all high priority.
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      priority_first  <= PIP_RST_PRIORITY_FIRST;
      priority_second <= PIP_RST_PRIORITY_SECOND;
    end
    else if (wr_fire)
    begin
      if (PADDR_I == PIP_OFS_PRIORITY_FIRST)
        priority_first <= PWDATA_I[7:0];
      if (PADDR_I == PIP_OFS_PRIORITY_SECOND)
        priority_second <= PWDATA_I[3:0];
    end
  end

  // Global priority enable and peripheral gate. The other reset control
  // flags belong to the reset unit and are not kept here.
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      global_priority_enable <= PIP_RST_GLOBAL_PRIO;
      peripheral_irq_gate    <= PIP_RST_IRQ_GATE;
    end
    else if (wr_fire)
    begin
      if (PADDR_I == PIP_OFS_RESET_CONTROL)
        global_priority_enable <= PWDATA_I[PIP_BIT_GLOBAL_PRIO];
      if (PADDR_I == PIP_OFS_IRQ_GATE)
        peripheral_irq_gate <= PWDATA_I[PIP_BIT_IRQ_GATE];
    end
  end

  // ========================================================================
  // Source gating. Enable-two bits map straight onto the second group.
  // enable-two gating
  pip_src_gate #(
    .N (12)
  ) u_gate (
    .flag_i     (FLAG_I),
    .enable_i   ({EN_FIRST_I, enable_second}),
    .prio_i     ({priority_first, priority_second}),
    .any_high_o (any_high),
    .any_low_o  (any_low),
    .any_o      (any_req)
  );

  // With priority enabled the gate arms the low level only; in compatible
  // mode every source goes to one vector and the gate must be open.
  always_comb
  begin
    if (global_priority_enable)
    begin
      next_req.high = any_high;
      next_req.low  = any_low & peripheral_irq_gate;
    end
    else
    begin
      next_req.high = any_req & peripheral_irq_gate;
      next_req.low  = 1'b0;
    end
  end

  // Requests are registered, costing one cycle of latency.
  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      REQ_O       <= '0;
      PRIO_MODE_O <= PIP_RST_GLOBAL_PRIO;
    end
    else
    begin
      REQ_O       <= next_req;
      PRIO_MODE_O <= global_priority_enable;
    end
  end

  // ========================================================================
  // Assertions.
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  AST_EN2_UPPER_ZERO: assert property (
    (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == PIP_OFS_ENABLE_SECOND)
    |=> PRDATA_O[31:4] == 28'h0 && PRDATA_O[3:0] == $past(enable_second))
    else $error("Enable-two read shows upper bits or stale data.");

  AST_LVD_BLOCKED: assert property (
    (FLAG_I == 12'h004 && !enable_second[PIP_BIT_LOW_VOLTAGE])
    |=> !REQ_O.high && !REQ_O.low)
    else $error("Disabled low-voltage flag raised a request.");

  AST_TIMER_THREE_PASSES: assert property (
    (FLAG_I == 12'h002 && enable_second[PIP_BIT_TIMER_THREE] && peripheral_irq_gate
     && !global_priority_enable) |=> REQ_O.high)
    else $error("Enabled timer-three flag gave no request.");

  AST_CAPCOMP_TWO_BLOCKED: assert property (
    (FLAG_I == 12'h001 && !enable_second[PIP_BIT_CAPCOMP_TWO])
    |=> !REQ_O.high && !REQ_O.low)
    else $error("Disabled capture/compare-two flag raised a request.");

  AST_LOW_PRIO_SOURCE: assert property (
    (FLAG_I == 12'h010 && EN_FIRST_I[0] && !priority_first[0] && peripheral_irq_gate
     && global_priority_enable) |=> REQ_O.low && !REQ_O.high)
    else $error("Low-priority source not routed to the low request.");

  AST_NO_LOW_COMPAT: assert property (
    !global_priority_enable |=> !REQ_O.low)
    else $error("Low request while priority scheme is off.");

  AST_PRIO_EN_WRITE: assert property (
    (wr_fire && PADDR_I == PIP_OFS_RESET_CONTROL)
    |=> global_priority_enable == $past(PWDATA_I[PIP_BIT_GLOBAL_PRIO])
        ##1 PRIO_MODE_O == $past(PWDATA_I[PIP_BIT_GLOBAL_PRIO], 2))
    else $error("Priority enable did not follow the write.");

  AST_GATE_CLOSED: assert property (
    (!global_priority_enable && !peripheral_irq_gate) |=> !REQ_O.high && !REQ_O.low)
    else $error("Request passed a closed peripheral gate.");

  AST_PRIO1_WRITE: assert property (
    (wr_fire && PADDR_I == PIP_OFS_PRIORITY_FIRST)
    |=> priority_first == $past(PWDATA_I[7:0]))
    else $error("Priority-one register did not take the write.");

  COV_WRITE_READ: cover property (wr_fire ##[1:20] (PREADY_O && !PWRITE_I));
  COV_HIGH_REQ:   cover property (global_priority_enable && REQ_O.high);
  COV_LOW_REQ:    cover property (REQ_O.low);
  COV_BAD_ADDR:   cover property (PSLVERR_O);

endmodule

// ### tb/pip_far_model.sv
// Far-side model: peripheral flag sources, the first enable group and the
// CPU vectoring input. Assumes the bench sets wanted levels between edges.
`timescale 1ns/1ps
module pip_far_model
  import pip_pkg::*;
(
  input  wire logic              mclk_i,     // Core clock.
  input  wire logic              arst_n_i,   // Reset, active low.
  input  wire pip_pkg::pip_src_t set_flag_i, // Wanted flag levels.
  input  wire logic [7:0]        set_en_i,   // Wanted first enables.
  input  wire pip_pkg::pip_req_t req_i,      // Requests from the block.
  output pip_pkg::pip_src_t      flag_o,     // Flags to the block.
  output logic [7:0]             en_o,       // First enables to the block.
  output logic [1:0]             taken_o     // Request seen, high then low.
);
  // ==========================================================================
  // Sources move only on an edge, as real peripherals do; the vectoring
  // side samples the request lines every edge, so a glitch would be seen.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flag_o  <= '0;
      en_o    <= 8'h00;
      taken_o <= 2'h0;
    end
    else
    begin
      flag_o  <= set_flag_i;
      en_o    <= set_en_i;
      taken_o <= req_i;
    end
  end
endmodule

// ### tb/tb_top.sv
// Bench for the peripheral enable and priority registers: APB tasks and
// request checks. Waits for ready however long the slave takes.
`timescale 1ns/1ps
module tb_top;
  import pip_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, prio_mode;
  logic [7:0] paddr, en_first, set_en;
  logic [31:0] pwdata, prdata;
  pip_src_t flag, set_flag;
  pip_req_t req;
  logic [1:0] taken;
  int miscompares = 0;
  int tests_run = 0;

  pip_irq_regs i_pip_irq_regs (.MCLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .FLAG_I(flag),
    .EN_FIRST_I(en_first), .REQ_O(req), .PRIO_MODE_O(prio_mode));
  pip_far_model i_pip_far_model (.mclk_i(clk), .arst_n_i(arst_n), .set_flag_i(set_flag),
    .set_en_i(set_en), .req_i(req), .flag_o(flag), .en_o(en_first), .taken_o(taken));

  // ==========================================================================
  // Clock of 4 ns.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks. A ready that never comes is ended by the watchdog.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk("prdata", exp, rd);
    chk("pslverr", {31'h0, err_exp}, {31'h0, err});
  endtask

  // Requests are levels; three edges cover the register and model stages.
  task automatic req_chk(input logic [1:0] exp);
    repeat (3) @(posedge clk);
    chk("request", {30'h0, exp}, {30'h0, taken});
  endtask

  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog: the tests need about 370 cycles.
  initial
  begin
    #40000;
    miscompares++;
    close_out();
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    arst_n = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    set_flag = '0;
    set_en = 8'h00;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk(8'h00, 32'h0, 1'b0);
    rd_chk(8'h04, 32'hff, 1'b0);
    rd_chk(8'h08, 32'hf, 1'b0);
    rd_chk(8'h0c, 32'h0, 1'b0);
    rd_chk(8'h10, 32'h0, 1'b0);
    wr(8'h00, 32'hffff_fff0);
    rd_chk(8'h00, 32'h0, 1'b0);
    wr(8'h04, 32'hffff_ff5a);
    rd_chk(8'h04, 32'h5a, 1'b0);
    wr(8'h08, 32'h0000_00fa);
    rd_chk(8'h08, 32'ha, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h1);
    // Walk each enable-two bit through both modes and both gate states.
    for (int i = 0; i < 4; i++)
    begin
      set_flag <= {8'h00, 4'(1 << i)};
      wr(8'h00, 32'(1 << i));
      rd_chk(8'h00, 32'(1 << i), 1'b0);
      req_chk(2'b10);
      wr(8'h10, 32'h0);
      req_chk(2'b00);
      wr(8'h10, 32'h1);
      wr(8'h00, 32'(4'hf ^ 4'(1 << i)));
      req_chk(2'b00);
      wr(8'h0c, 32'h80);
      wr(8'h00, 32'(1 << i));
      req_chk(2'b01);
      wr(8'h08, 32'(1 << i));
      wr(8'h10, 32'h0);
      req_chk(2'b10);
      wr(8'h10, 32'h1);
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h0);
    end
    set_flag <= '0;
    wr(8'h0c, 32'h8000_0080);
    rd_chk(8'h0c, 32'h80, 1'b0);
    chk("prio_mode", 32'h1, {31'h0, prio_mode});
    for (int j = 0; j < 8; j++)
    begin
      set_flag <= {8'(1 << j), 4'h0};
      set_en <= 8'(1 << j);
      wr(8'h04, 32'(8'hff ^ 8'(1 << j)));
      req_chk(2'b01);
      wr(8'h04, 32'(1 << j));
      req_chk(2'b10);
    end
    // A reset in mid-run must bring back the power-on values at once.
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("prio_mode", 32'h0, {31'h0, prio_mode});
    rd_chk(8'h04, 32'hff, 1'b0);
    rd_chk(8'h00, 32'h0, 1'b0);
    req_chk(2'b00);
    close_out();
  end
endmodule
